/* File: src/scc_pkg.sv */
package scc_pkg;

    // Clock and timing.
    localparam int CLK_NS = 10;
    localparam int STEP_NS = 500;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = (SETTLE_US * 1000) / CLK_NS;

    // Command byte fields.
    localparam int CMD_SEL_HI = 7;
    localparam int CMD_SEL_LO = 5;
    localparam int CMD_BANK_BIT = 7;
    localparam int CMD_ADDR_A_BIT = 5;
    localparam int CMD_ADDR_B_BIT = 6;
    localparam int CMD_RST_BIT = 4;
    localparam int CMD_CLK_HI = 3;
    localparam int CMD_CLK_LO = 2;
    localparam int CMD_VCC_HI = 1;
    localparam int CMD_VCC_LO = 0;
    localparam int CMD_SCLK_BIT = 3;
    localparam int CMD_IO_BIT = 2;
    localparam int CMD_AUXA_BIT = 1;
    localparam int CMD_AUXB_BIT = 0;
    localparam int CMD_CFG_HI = 4;

    // Selector codes in the top three bits.
    localparam logic [2:0] SEL_EXT_ASYNC = 3'h4;
    localparam logic [2:0] SEL_CONFIG = 3'h5;
    localparam logic [2:0] SEL_SYNC = 3'h6;
    localparam logic [2:0] SEL_RFU = 3'h7;

    // Configuration codes in the low five bits.
    localparam logic [4:0] CFG_DET_NO = 5'h00;
    localparam logic [4:0] CFG_DET_NC = 5'h01;
    localparam logic [4:0] CFG_SPECIAL = 5'h02;
    localparam logic [4:0] CFG_NORMAL = 5'h03;
    localparam logic [4:0] CFG_SLOW = 5'h04;
    localparam logic [4:0] CFG_FAST = 5'h05;

    typedef enum logic [1:0] {
        SCC_VCC_OFF = 2'h0,
        SCC_VCC_1V8 = 2'h1,
        SCC_VCC_3V0 = 2'h2,
        SCC_VCC_5V0 = 2'h3
    } scc_vcc_t;

    localparam logic [1:0] CLKSEL_LOW = 2'h0;
    localparam logic [1:0] CLKSEL_DIV1 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV2 = 2'h2;
    localparam logic [1:0] CLKSEL_DIV4 = 2'h3;

    // Values after power-on reset.
    localparam logic RST_DET_NC = 1'b0;
    localparam logic RST_NORMAL = 1'b0;
    localparam logic RST_FAST = 1'b0;
    localparam logic [1:0] RST_CLKSEL = 2'h0;

    // Status byte layout.
    localparam int ST_PWR = 0;
    localparam int ST_AUXB = 1;
    localparam int ST_AUXA = 2;
    localparam int ST_IO = 3;
    localparam int ST_DET = 4;
    localparam int ST_W = 5;
    localparam logic [2:0] ST_FIRST_DRIVEN = 3'h3;

    // Power-down force mask, in sequence order.
    localparam int PD_RST = 0;
    localparam int PD_CLK = 1;
    localparam int PD_AUX = 2;
    localparam int PD_IO = 3;
    localparam int PD_VCC = 4;
    localparam int PD_STEPS = 5;

endpackage

/* File: src/scc_seq_if.sv */
`timescale 1ns/1ns
interface scc_seq_if;
    logic start;
    logic done;
    logic [scc_pkg::PD_STEPS-1:0] force_low;

    modport ctrl (output start, input done, input force_low);
    modport seq (input start, output done, output force_low);
endinterface

/* File: src/scc_pdown_seq.sv */
`timescale 1ns/1ns
module scc_pdown_seq #(
    parameter int STEP_CYC = scc_pkg::STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    scc_seq_if.seq sq
);
    localparam int TW = $clog2(STEP_CYC + 1);
    localparam logic [TW-1:0] TMR_LAST = TW'(STEP_CYC - 1);
    localparam logic [2:0] STEP_LAST = 3'(scc_pkg::PD_STEPS - 1);

    typedef enum logic [1:0] {
        SCC_PD_IDLE = 2'b01,
        SCC_PD_RUN = 2'b10
    } scc_pd_state_t;

    scc_pd_state_t state_r, state_nxt;
    logic [2:0] step_r, step_nxt;
    logic [TW-1:0] tmr_r, tmr_nxt;
    logic [scc_pkg::PD_STEPS-1:0] force_r, force_nxt;
    logic done_r, done_nxt;

    // Each step adds one more signal held low; the last one removes the supply.
    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        tmr_nxt = tmr_r;
        force_nxt = force_r;
        done_nxt = 1'b0;
        case (state_r)
            SCC_PD_IDLE: begin
                force_nxt = '0;
                if (sq.start) begin
                    state_nxt = SCC_PD_RUN;
                    step_nxt = 3'h0;
                    tmr_nxt = '0;
                    force_nxt = 5'h01;
                end
            end
            SCC_PD_RUN: begin
                if (tmr_r == TMR_LAST) begin
                    tmr_nxt = '0;
                    if (step_r == STEP_LAST) begin
                        done_nxt = 1'b1;
                        state_nxt = SCC_PD_IDLE;
                    end else begin
                        step_nxt = step_r + 3'h1;
                        force_nxt = {force_r[scc_pkg::PD_STEPS-2:0], 1'b1};
                    end
                end else begin
                    tmr_nxt = tmr_r + TW'(1);
                end
            end
            default: begin
                state_nxt = SCC_PD_IDLE;
                force_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SCC_PD_IDLE;
            step_r <= 3'h0;
            tmr_r <= '0;
            force_r <= '0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            tmr_r <= tmr_nxt;
            force_r <= force_nxt;
            done_r <= done_nxt;
        end
    end

    assign sq.force_low = force_r;
    assign sq.done = done_r;
endmodule

/* File: src/scc_top.sv */
// What this block does
// - Status byte shifts out on the return line while a command shifts in.
// - Return line changes on rising clock edge in special mode, falling in normal.
// - Status: bit4 presence, bit3 data line, bits2-1 aux pins, bit0 supply flag.
// - Asynchronous mode uses both aux pins as address inputs, four per select.
// - Synchronous command drives reset, clock, data, aux a, aux b from bits 4..0.
// - Programming command drives the card reset pin low at once.
// - Power-on: normally open detect, supply off, slow edges, clock low, special.
// - Detect switch polarity follows the last programmed setting, normally open by default.
// - Normal mode: status bit 4 high when a card is inserted, any polarity.
// - Special mode: status bit 4 is the raw detect switch level.
// - Supply field selects off, 1.8 V, 3.0 V or 5.0 V.
// - Supply outside its window: converter off, power-down run, alert raised.
// - Selector 101 sets switch polarity, serial edge mode and clock edge speed.
// - Asynchronous command accepted only when its address bits match the aux pins; selector 100 needs no match.
// - Power-down drops reset, clock, aux pins, data line, then the supply, in order.
// - Alert goes low on insertion, extraction or supply fault, regardless of select.
`timescale 1ns/1ns
module scc_top #(
    parameter int SETTLE_CYC = scc_pkg::SETTLE_CYC,
    parameter int STEP_CYC = scc_pkg::STEP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic card_detect_switch,
    input wire logic supply_good_flag,
    input wire logic card_aux_pin_a_i,
    output logic card_aux_pin_a_o,
    output logic card_aux_pin_a_oe,
    input wire logic card_aux_pin_b_i,
    output logic card_aux_pin_b_o,
    output logic card_aux_pin_b_oe,
    input wire logic card_data_line_i,
    output logic card_data_line_o,
    output logic card_data_line_oe,
    output logic card_reset_pin,
    output logic card_clock,
    output logic [1:0] card_supply,
    output logic converter_en,
    output logic fast_edge_setting,
    output logic alert_n
);
    localparam int SW = $clog2(SETTLE_CYC + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: command shift-in and status shift-out.

    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [6:0] rx_r, rx_nxt;
    logic [7:0] cmd_byte_r, cmd_byte_nxt;
    logic cmd_tgl_r, cmd_tgl_nxt;
    logic [2:0] neg_idx_r, neg_idx_nxt;
    logic pos_bit_r, pos_bit_nxt;
    logic neg_bit_r, neg_bit_nxt;
    logic [scc_pkg::ST_W-1:0] lst_s1_r, lst_s2_r;
    logic lmode_s1_r, lmode_s2_r;
    logic [scc_pkg::ST_W-1:0] stat_r, stat_nxt;
    logic normal_r, normal_nxt;

    // Bit shown at a given position of the frame, most significant first.
    function automatic logic stat_bit(input logic [2:0] idx, input logic [4:0] st);
        logic [2:0] pos;
        pos = 3'h7 - idx;
        stat_bit = (idx < scc_pkg::ST_FIRST_DRIVEN) ? 1'b0 : st[pos];
    endfunction

    always_comb begin
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        rx_nxt = {rx_r[5:0], mosi};
        cmd_byte_nxt = cmd_byte_r;
        cmd_tgl_nxt = cmd_tgl_r;
        if (bit_cnt_r == 3'h7) begin
            cmd_byte_nxt = {rx_r, mosi};
            cmd_tgl_nxt = ~cmd_tgl_r;
        end
        neg_idx_nxt = neg_idx_r + 3'h1;
        pos_bit_nxt = stat_bit(bit_cnt_nxt, lst_s2_r);
        neg_bit_nxt = stat_bit(neg_idx_nxt, lst_s2_r);
    end

    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 3'h0;
            rx_r <= 7'h00;
            pos_bit_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            rx_r <= rx_nxt;
            pos_bit_r <= pos_bit_nxt;
        end
    end

    always_ff @(negedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            neg_idx_r <= 3'h0;
            neg_bit_r <= 1'b0;
        end else begin
            neg_idx_r <= neg_idx_nxt;
            neg_bit_r <= neg_bit_nxt;
        end
    end

    // The byte and its toggle outlive the frame so the core can pick them up.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_byte_r <= 8'h00;
            cmd_tgl_r <= 1'b0;
            lst_s1_r <= '0;
            lst_s2_r <= '0;
            lmode_s1_r <= scc_pkg::RST_NORMAL;
            lmode_s2_r <= scc_pkg::RST_NORMAL;
        end else begin
            cmd_byte_r <= cmd_byte_nxt;
            cmd_tgl_r <= cmd_tgl_nxt;
            lst_s1_r <= stat_r;
            lst_s2_r <= lst_s1_r;
            lmode_s1_r <= normal_r;
            lmode_s2_r <= lmode_s1_r;
        end
    end

    assign miso = lmode_s2_r ? neg_bit_r : pos_bit_r;
    // Top three positions and idle select leave the line floating.
    assign miso_oe = ~cs_n & ((lmode_s2_r ? neg_idx_r : bit_cnt_r)
                              >= scc_pkg::ST_FIRST_DRIVEN);

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain: pin synchronisers and command pickup.

    logic [4:0] in_s1_r, in_s2_r;
    logic det_d_r;
    logic tg_s1_r, tg_s2_r, tg_s3_r;
    logic det_s, io_s, auxa_s, auxb_s, pwr_s;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_r <= 5'h00;
            in_s2_r <= 5'h00;
            det_d_r <= 1'b0;
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_s3_r <= 1'b0;
        end else begin
            in_s1_r <= {card_detect_switch, card_data_line_i, card_aux_pin_a_i,
                        card_aux_pin_b_i, supply_good_flag};
            in_s2_r <= in_s1_r;
            det_d_r <= in_s2_r[4];
            tg_s1_r <= cmd_tgl_r;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end

    assign det_s = in_s2_r[4];
    assign io_s = in_s2_r[3];
    assign auxa_s = in_s2_r[2];
    assign auxb_s = in_s2_r[1];
    assign pwr_s = in_s2_r[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain: decode, card control and supply supervision.

    scc_seq_if sq ();

    scc_pdown_seq #(
        .STEP_CYC(STEP_CYC)
    ) u_pdown (
        .mclk(mclk),
        .rst_n(rst_n),
        .sq(sq.seq)
    );

    logic nc_r, nc_nxt;
    logic fast_r, fast_nxt;
    logic [1:0] vcc_r, vcc_nxt;
    logic [1:0] clksel_r, clksel_nxt;
    logic sync_mode_r, sync_mode_nxt;
    logic rst_pin_r, rst_pin_nxt;
    logic clk_lvl_r, clk_lvl_nxt;
    logic io_r, io_nxt;
    logic auxa_r, auxa_nxt;
    logic auxb_r, auxb_nxt;
    logic alert_r, alert_nxt;
    logic [2:0] div_r, div_nxt;
    logic card_clk_r, card_clk_nxt;
    logic [SW-1:0] settle_r, settle_nxt;
    logic pd_start_r, pd_start_nxt;

    logic new_cmd, inserted, ins_d, pd_busy, fault, det_event, clr;
    logic [2:0] sel;
    logic [4:0] force_low;

    assign force_low = sq.force_low;
    assign sq.start = pd_start_r;

    always_comb begin
        nc_nxt = nc_r;
        normal_nxt = normal_r;
        fast_nxt = fast_r;
        vcc_nxt = vcc_r;
        clksel_nxt = clksel_r;
        sync_mode_nxt = sync_mode_r;
        rst_pin_nxt = rst_pin_r;
        clk_lvl_nxt = clk_lvl_r;
        io_nxt = io_r;
        auxa_nxt = auxa_r;
        auxb_nxt = auxb_r;
        div_nxt = div_r + 3'h1;
        pd_start_nxt = 1'b0;
        clr = 1'b0;

        new_cmd = tg_s2_r ^ tg_s3_r;
        sel = cmd_byte_r[scc_pkg::CMD_SEL_HI:scc_pkg::CMD_SEL_LO];
        inserted = nc_r ? det_s : ~det_s;
        ins_d = nc_r ? det_d_r : ~det_d_r;
        det_event = det_s ^ det_d_r;
        pd_busy = pd_start_r | (|force_low);
        fault = (vcc_r != scc_pkg::SCC_VCC_OFF) && (settle_r == SETTLE_LAST)
                && !pwr_s && !pd_busy;

        // Commands are dropped while the card is being shut down.
        if (new_cmd && !pd_busy) begin
            if (!cmd_byte_r[scc_pkg::CMD_BANK_BIT] || sel == scc_pkg::SEL_EXT_ASYNC) begin
                // Bank commands only reach the chip whose aux pins match the address.
                if (sel == scc_pkg::SEL_EXT_ASYNC || (!sync_mode_r
                    && cmd_byte_r[scc_pkg::CMD_ADDR_A_BIT] == auxa_s
                    && cmd_byte_r[scc_pkg::CMD_ADDR_B_BIT] == auxb_s)) begin
                    clr = 1'b1;
                    if (sel != scc_pkg::SEL_EXT_ASYNC) begin
                        sync_mode_nxt = 1'b0;
                    end
                    rst_pin_nxt = cmd_byte_r[scc_pkg::CMD_RST_BIT];
                    clksel_nxt = cmd_byte_r[scc_pkg::CMD_CLK_HI:scc_pkg::CMD_CLK_LO];
                    // Turning an active supply off goes through the ordered shutdown.
                    if (cmd_byte_r[scc_pkg::CMD_VCC_HI:scc_pkg::CMD_VCC_LO] == scc_pkg::SCC_VCC_OFF
                        && vcc_r != scc_pkg::SCC_VCC_OFF) begin
                        pd_start_nxt = 1'b1;
                    end else begin
                        vcc_nxt = cmd_byte_r[scc_pkg::CMD_VCC_HI:scc_pkg::CMD_VCC_LO];
                    end
                end
            end else if (sel == scc_pkg::SEL_SYNC) begin
                sync_mode_nxt = 1'b1;
                rst_pin_nxt = cmd_byte_r[scc_pkg::CMD_RST_BIT];
                clk_lvl_nxt = cmd_byte_r[scc_pkg::CMD_SCLK_BIT];
                io_nxt = cmd_byte_r[scc_pkg::CMD_IO_BIT];
                auxa_nxt = cmd_byte_r[scc_pkg::CMD_AUXA_BIT];
                auxb_nxt = cmd_byte_r[scc_pkg::CMD_AUXB_BIT];
            end else if (sel == scc_pkg::SEL_CONFIG) begin
                clr = 1'b1;
                rst_pin_nxt = 1'b0;
                case (cmd_byte_r[scc_pkg::CMD_CFG_HI:0])
                    scc_pkg::CFG_DET_NO: nc_nxt = 1'b0;
                    scc_pkg::CFG_DET_NC: nc_nxt = 1'b1;
                    scc_pkg::CFG_SPECIAL: normal_nxt = 1'b0;
                    scc_pkg::CFG_NORMAL: normal_nxt = 1'b1;
                    scc_pkg::CFG_SLOW: fast_nxt = 1'b0;
                    scc_pkg::CFG_FAST: fast_nxt = 1'b1;
                    default: nc_nxt = nc_r;
                endcase
            end
        end

        // Extraction or a supply leaving its window starts the shutdown.
        if (!pd_busy && vcc_r != scc_pkg::SCC_VCC_OFF && (fault || (ins_d && !inserted))) begin
            pd_start_nxt = 1'b1;
        end

        // Sequence finished: the card side returns to its idle state.
        if (sq.done) begin
            vcc_nxt = scc_pkg::SCC_VCC_OFF;
            rst_pin_nxt = 1'b0;
            clksel_nxt = scc_pkg::CLKSEL_LOW;
            clk_lvl_nxt = 1'b0;
            io_nxt = 1'b0;
            auxa_nxt = 1'b0;
            auxb_nxt = 1'b0;
        end

        settle_nxt = settle_r;
        if (vcc_r == scc_pkg::SCC_VCC_OFF) begin
            settle_nxt = '0;
        end else if (settle_r != SETTLE_LAST) begin
            settle_nxt = settle_r + SW'(1);
        end

        // A new event wins over a clear in the same cycle.
        alert_nxt = det_event | fault | (alert_r & ~clr);

        case (clksel_r)
            scc_pkg::CLKSEL_DIV1: card_clk_nxt = div_r[0];
            scc_pkg::CLKSEL_DIV2: card_clk_nxt = div_r[1];
            scc_pkg::CLKSEL_DIV4: card_clk_nxt = div_r[2];
            default: card_clk_nxt = 1'b0;
        endcase
        if (sync_mode_r) begin
            card_clk_nxt = clk_lvl_r;
        end

        stat_nxt = '0;
        stat_nxt[scc_pkg::ST_DET] = normal_r ? inserted : det_s;
        stat_nxt[scc_pkg::ST_IO] = io_s;
        stat_nxt[scc_pkg::ST_AUXA] = auxa_s;
        stat_nxt[scc_pkg::ST_AUXB] = auxb_s;
        stat_nxt[scc_pkg::ST_PWR] = pwr_s;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nc_r <= scc_pkg::RST_DET_NC;
            normal_r <= scc_pkg::RST_NORMAL;
            fast_r <= scc_pkg::RST_FAST;
            vcc_r <= scc_pkg::SCC_VCC_OFF;
            clksel_r <= scc_pkg::RST_CLKSEL;
            sync_mode_r <= 1'b0;
            rst_pin_r <= 1'b0;
            clk_lvl_r <= 1'b0;
            io_r <= 1'b0;
            auxa_r <= 1'b0;
            auxb_r <= 1'b0;
            alert_r <= 1'b0;
            div_r <= 3'h0;
            card_clk_r <= 1'b0;
            settle_r <= '0;
            pd_start_r <= 1'b0;
            stat_r <= '0;
        end else begin
            nc_r <= nc_nxt;
            normal_r <= normal_nxt;
            fast_r <= fast_nxt;
            vcc_r <= vcc_nxt;
            clksel_r <= clksel_nxt;
            sync_mode_r <= sync_mode_nxt;
            rst_pin_r <= rst_pin_nxt;
            clk_lvl_r <= clk_lvl_nxt;
            io_r <= io_nxt;
            auxa_r <= auxa_nxt;
            auxb_r <= auxb_nxt;
            alert_r <= alert_nxt;
            div_r <= div_nxt;
            card_clk_r <= card_clk_nxt;
            settle_r <= settle_nxt;
            pd_start_r <= pd_start_nxt;
            stat_r <= stat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Card-side outputs with the shutdown forcing applied.

    assign card_reset_pin = rst_pin_r & ~force_low[scc_pkg::PD_RST];
    assign card_clock = card_clk_r & ~force_low[scc_pkg::PD_CLK];
    assign card_aux_pin_a_o = auxa_r & sync_mode_r & ~force_low[scc_pkg::PD_AUX];
    assign card_aux_pin_b_o = auxb_r & sync_mode_r & ~force_low[scc_pkg::PD_AUX];
    // Aux pins stay inputs in asynchronous mode, except while the shutdown drives them low, so they can carry the address.
    assign card_aux_pin_a_oe = sync_mode_r | force_low[scc_pkg::PD_AUX];
    assign card_aux_pin_b_oe = sync_mode_r | force_low[scc_pkg::PD_AUX];
    assign card_data_line_o = io_r & sync_mode_r & ~force_low[scc_pkg::PD_IO];
    assign card_data_line_oe = sync_mode_r | force_low[scc_pkg::PD_IO];
    assign card_supply = force_low[scc_pkg::PD_VCC] ? scc_pkg::SCC_VCC_OFF : vcc_r;
    assign converter_en = (vcc_r != scc_pkg::SCC_VCC_OFF) & ~force_low[scc_pkg::PD_VCC];
    assign fast_edge_setting = fast_r;
    assign alert_n = ~alert_r;
endmodule

/* File: verification/scc_top_asserts.sv */
`timescale 1ns/1ns
module scc_top_asserts (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic miso_oe,
    input wire logic card_detect_switch,
    input wire logic card_reset_pin,
    input wire logic card_clock,
    input wire logic card_data_line_o,
    input wire logic card_data_line_oe,
    input wire logic [1:0] card_supply,
    input wire logic converter_en,
    input wire logic fast_edge_setting,
    input wire logic alert_n
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_pd_end;
        $fell(converter_en);
    endsequence
    property p_oe_off; cs_n |-> !miso_oe; endproperty
    property p_oe_top; $fell(cs_n) |-> !miso_oe; endproperty
    property p_por; $rose(resetn) |-> alert_n && card_supply == 2'h0; endproperty
    property p_conv; converter_en |-> card_supply != 2'h0; endproperty
    property p_pd_order; s_pd_end |-> !card_reset_pin && !card_clock; endproperty
    property p_sup_last; $changed(card_supply) && card_supply == 2'h0 |->
        $past(card_data_line_oe) && !$past(card_data_line_o);
    endproperty
    property p_alert; $changed(card_detect_switch) |-> ##[1:8] !alert_n; endproperty
    property p_cfg; $changed(fast_edge_setting) |-> ##[0:1] !card_reset_pin; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe deselected");
    a_oe_top: assert property (p_oe_top) else $error("oe on top bits");
    a_por: assert property (p_por) else $error("reset values");
    a_conv: assert property (p_conv) else $error("converter on at zero");
    a_pd_order: assert property (p_pd_order) else $error("supply off too early");
    a_sup_last: assert property (p_sup_last) else $error("supply off before data low");
    a_alert: assert property (p_alert) else $error("no alert");
    a_cfg: assert property (p_cfg) else $error("reset pin high on config");
endmodule
bind scc_top scc_top_asserts u_chk (.mclk, .resetn, .cs_n, .miso_oe, .card_detect_switch,
    .card_reset_pin, .card_clock, .card_data_line_o, .card_data_line_oe, .card_supply,
    .converter_en, .fast_edge_setting, .alert_n);

/* File: verification/scc_host.sv */
`timescale 1ns/1ns
module scc_host (
    output logic link_clk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] ph;
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // This host gives the device its own chip select.
    task automatic xfer(input logic [7:0] cmd);
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < 8; i++) begin
            mosi = cmd[7 - i];
            #8 link_clk = 1'b1;
            #8 ph = {ph[6:0], miso};
            #8 link_clk = 1'b0;
            #8;
        end
        cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule

/* File: verification/smart_card_serial_command_readback_test.sv */
`timescale 1ns/1ns
module smart_card_serial_command_readback_test;
    logic resetn = 1'b0, det = 1'b0, good = 1'b1, aux_a = 1'b1, aux_b = 1'b0, dat = 1'b1;
    logic mclk, lclk, cs_n, mosi, miso, oe, ao, aoe, bo, boe, d_o, doe;
    logic rpin, cclk, conv, fast, alert_n;
    logic [1:0] sup;
    logic nrm = 1'b0, nc = 1'b0;
    int fails = 0, n_tests = 0;
    wire a_w = aoe ? ao : aux_a;
    wire b_w = boe ? bo : aux_b;
    wire d_w = doe ? d_o : dat;
    logic [15:0] rows [11] = '{16'h3116, 16'h2a18, 16'h9f1e, 16'h511e, 16'hf01e, 16'ha51d,
        16'ha31d, 16'ha11d, 16'ha41c, 16'h2010, 16'ha200};
    scc_top #(.SETTLE_CYC(20), .STEP_CYC(4)) dut (.mclk, .resetn, .link_clk(lclk), .cs_n,
        .mosi, .miso, .miso_oe(oe), .card_detect_switch(det), .supply_good_flag(good),
        .card_aux_pin_a_i(a_w), .card_aux_pin_a_o(ao), .card_aux_pin_a_oe(aoe),
        .card_aux_pin_b_i(b_w), .card_aux_pin_b_o(bo), .card_aux_pin_b_oe(boe),
        .card_data_line_i(d_w), .card_data_line_o(d_o), .card_data_line_oe(doe),
        .card_reset_pin(rpin), .card_clock(cclk), .card_supply(sup), .converter_en(conv),
        .fast_edge_setting(fast), .alert_n);
    scc_host host (.link_clk(lclk), .cs_n, .mosi, .miso(oe ? miso : ~miso));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] cmd);
        logic [4:0] st;
        st = {nrm ? ~(nc ^ det) : det, d_w, a_w, b_w, good};
        host.xfer(cmd);
        chk("status", {3'h0, st},
            {3'h0, nrm ? host.ph[4:0] : host.ph[5:1]});
        if (cmd[7:1] == 7'h51) nrm = cmd[0];
        if (cmd[7:1] == 7'h50) nc = cmd[0];
        repeat (40) @(negedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        chk("reset", 8'h08, {2'h0, sup, alert_n, fast, cclk, rpin});
        for (int i = 0; i < 11; i++) begin
            det = rows[i][4];
            frame(rows[i][15:8]);
            chk("row", {4'h0, rows[i][3:0]}, {4'h0, sup, rpin, fast});
        end
        frame(8'h9a);
        frame(8'hd5);
        chk("sync", 8'haf, {rpin, cclk, d_o, ao, bo, doe, aoe, boe});
        frame(8'h21);
        chk("sync_bank", 8'h02, {6'h0, sup});
        good = 1'b0;
        for (int k = 0; k < 400 && conv === 1'b1; k++) @(negedge mclk);
        repeat (60) @(negedge mclk);
        chk("fault", 8'h00, {4'h0, conv, sup, alert_n});
        good = 1'b1;
        frame(8'h80);
        chk("alert_clear", 8'h01, {7'h0, alert_n});
        frame(8'h9f);
        resetn = 1'b0;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        chk("reset_mid", 8'h08, {2'h0, sup, alert_n, fast, cclk, rpin});
        close_out;
    end
endmodule
